//--- inc/aosm_defs.vh
// Constants for the auxiliary output source selector
`ifndef AOSM_DEFS_VH
`define AOSM_DEFS_VH
// Printed offsets are not multiples of four, so they are word indices
`define AOSM_IDX_OUT3 12'h01d
`define AOSM_IDX_OUT4 12'h01e
`define AOSM_ADDR_OUT3 12'h074
`define AOSM_ADDR_OUT4 12'h078
`define AOSM_SEL_MSB 3
`define AOSM_SEL_RESET 4'h0
`define AOSM_SEL_LOW 4'h0
`define AOSM_SEL_HIGH 4'h1
`define AOSM_SEL_RATE_IRQ 4'h2
`define AOSM_SEL_TX_IRQ 4'h3
`define AOSM_SEL_RX_IRQ 4'h4
`define AOSM_SEL_PREEMPH 4'h5
`define AOSM_SEL_NONAUDIO 4'h6
`define AOSM_SEL_NONVALID 4'h7
`define AOSM_SEL_CS_BIT 4'h8
`define AOSM_SEL_USER_BIT 4'h9
`define AOSM_SEL_BLOCK_CLK 4'ha
`define AOSM_SEL_COPY 4'hb
`define AOSM_SEL_GEN 4'hc
`define AOSM_SEL_PARITY 4'hd
`define AOSM_SEL_RX_SYNC 4'he
`define AOSM_SEL_TX_SYNC 4'hf
`define AOSM_NSRC 14
`endif

//--- src/aosm_aux_output_source_mux.v
// Auxiliary output source selector with APB register access
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "aosm_defs.vh"
module aosm_aux_output_source_mux #(
  parameter ADDR_W = 12,
  parameter DATA_W = 32,
  parameter NSRC = `AOSM_NSRC
) (
  input wire mclk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [DATA_W-1:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [DATA_W-1:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire rate_converter_irq_n_i,
  input wire tx_irq_n_i,
  input wire rx_irq_n_i,
  input wire rx_preemph_n_i,
  input wire rx_nonaudio_i,
  input wire rx_nonvalid_i,
  input wire rx_cs_bit_i,
  input wire rx_user_bit_i,
  input wire rx_block_clk_i,
  input wire rx_copy_i,
  input wire rx_generation_i,
  input wire rx_parity_err_i,
  input wire rx_sync_clk_i,
  input wire tx_sync_clk_i,
  output reg aux_output_three_o,
  output reg aux_output_four_o
);
  localparam [ADDR_W-1:0] ADDR_OUT3 = `AOSM_ADDR_OUT3;
  localparam [ADDR_W-1:0] ADDR_OUT4 = `AOSM_ADDR_OUT4;

  reg [1:0] rst_sync;
  wire rst_n;
  reg [3:0] out_three_source_select;
  reg [3:0] out_four_source_select;
  reg [DATA_W-1:0] prdata;
  reg [DATA_W-1:0] next_prdata;
  wire [NSRC-1:0] src_raw;
  reg [NSRC-1:0] src_s1;
  reg [NSRC-1:0] src_s2;
  wire [7:0] sel_pair;
  wire [1:0] next_pin;
  wire hit3;
  wire hit4;
  wire access;
  wire rd_setup;
  wire wr3;
  wire wr4;

  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Sources come from other logic and are treated as asynchronous
  assign src_raw[0] = rate_converter_irq_n_i;
  assign src_raw[1] = tx_irq_n_i;
  assign src_raw[2] = rx_irq_n_i;
  assign src_raw[3] = rx_preemph_n_i;
  assign src_raw[4] = rx_nonaudio_i;
  assign src_raw[5] = rx_nonvalid_i;
  assign src_raw[6] = rx_cs_bit_i;
  assign src_raw[7] = rx_user_bit_i;
  assign src_raw[8] = rx_block_clk_i;
  assign src_raw[9] = rx_copy_i;
  assign src_raw[10] = rx_generation_i;
  assign src_raw[11] = rx_parity_err_i;
  assign src_raw[12] = rx_sync_clk_i;
  assign src_raw[13] = tx_sync_clk_i;

  // Two stages per source; only the second stage may feed the selector
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_sync
      always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          src_s1[gi] <= 1'b0;
        end else begin
          src_s1[gi] <= src_raw[gi];
        end
      end

      always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
          src_s2[gi] <= 1'b0;
        end else begin
          src_s2[gi] <= src_s1[gi];
        end
      end
    end
  endgenerate

  // Byte address is four times the register index
  assign hit3 = (paddr_i == ADDR_OUT3);
  assign hit4 = (paddr_i == ADDR_OUT4);
  assign access = psel_i && penable_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  // Only byte lane 0 carries the field, so its strobe gates the write
  assign wr3 = access && pwrite_i && pstrb_i[0] && hit3;
  assign wr4 = access && pwrite_i && pstrb_i[0] && hit4;
  assign pready_o = 1'b1;
  // Unmapped addresses answer with an error and read zero
  assign pslverr_o = access && !(hit3 || hit4);
  assign prdata_o = prdata;

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_three_source_select <= `AOSM_SEL_RESET;
    end else if (wr3) begin
      out_three_source_select <= pwdata_i[`AOSM_SEL_MSB:0];
    end
  end

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_four_source_select <= `AOSM_SEL_RESET;
    end else if (wr4) begin
      out_four_source_select <= pwdata_i[`AOSM_SEL_MSB:0];
    end
  end

  // Read data registered in setup phase so it stands through the access phase
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= {DATA_W{1'b0}};
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  always @* begin
    case ({hit4, hit3})
      2'b01: begin
        next_prdata = {{(DATA_W-4){1'b0}}, out_three_source_select};
      end
      2'b10: begin
        next_prdata = {{(DATA_W-4){1'b0}}, out_four_source_select};
      end
      default: begin
        next_prdata = {DATA_W{1'b0}};
      end
    endcase
  end

  assign sel_pair = {out_four_source_select, out_three_source_select};

  // One selector per output; both share the synchronised sources
  genvar go;
  generate
    for (go = 0; go < 2; go = go + 1) begin : g_mux
      reg pin_d;
      always @* begin
        case (sel_pair[go*4 +: 4])
          `AOSM_SEL_LOW: pin_d = 1'b0;
          `AOSM_SEL_HIGH: pin_d = 1'b1;
          `AOSM_SEL_RATE_IRQ: pin_d = src_s2[0];
          `AOSM_SEL_TX_IRQ: pin_d = src_s2[1];
          `AOSM_SEL_RX_IRQ: pin_d = src_s2[2];
          `AOSM_SEL_PREEMPH: pin_d = src_s2[3];
          `AOSM_SEL_NONAUDIO: pin_d = src_s2[4];
          `AOSM_SEL_NONVALID: pin_d = src_s2[5];
          `AOSM_SEL_CS_BIT: pin_d = src_s2[6];
          `AOSM_SEL_USER_BIT: pin_d = src_s2[7];
          `AOSM_SEL_BLOCK_CLK: pin_d = src_s2[8];
          `AOSM_SEL_COPY: pin_d = src_s2[9];
          `AOSM_SEL_GEN: pin_d = src_s2[10];
          `AOSM_SEL_PARITY: pin_d = src_s2[11];
          `AOSM_SEL_RX_SYNC: pin_d = src_s2[12];
          `AOSM_SEL_TX_SYNC: pin_d = src_s2[13];
          default: pin_d = 1'b0;
        endcase
      end
      assign next_pin[go] = pin_d;
    end
  endgenerate

  // Registered pins: no mux glitches reach the outside, at one cycle of latency
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_output_three_o <= 1'b0;
    end else begin
      aux_output_three_o <= next_pin[0];
    end
  end

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      aux_output_four_o <= 1'b0;
    end else begin
      aux_output_four_o <= next_pin[1];
    end
  end
endmodule // aosm_aux_output_source_mux

//--- verif/aosm_pin_watch.sv
// Far-side watcher counting rises on one pin
`timescale 1ns/1ps
module aosm_pin_watch (
  input logic rstn_i,
  input logic pin_i,
  output int rises_o
);
  // Clocked by the pin so a glitch counts too
  always @(posedge pin_i or negedge rstn_i) begin
    if (!rstn_i) rises_o <= 0;
    else rises_o <= rises_o + 1;
  end
endmodule // aosm_pin_watch

//--- verif/aosm_props_properties.sv
// Property checker for the aux output selector
`timescale 1ns/1ps
module aosm_props (
  input logic mclk_i, rstn_i, psel_i, penable_i, pwrite_i, pslverr_o,
  input logic aux_output_three_o, aux_output_four_o,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i, prdata_o,
  input logic [3:0] pstrb_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire acc = psel_i & penable_i;
  wire rd = acc & !pwrite_i;
  wire hit = paddr_i == 12'h074 || paddr_i == 12'h078;
  wire w3 = acc & pwrite_i & pstrb_i[0] & paddr_i == 12'h074;
  wire w4 = acc & pwrite_i & pstrb_i[0] & paddr_i == 12'h078;
  property p_h3; w3 && pwdata_i[3:0] == 1 |-> ##2 aux_output_three_o; endproperty
  a_h3: assert property (p_h3) else $error("pin3 low");
  property p_l3; w3 && pwdata_i[3:0] == 0 |-> ##2 !aux_output_three_o; endproperty
  a_l3: assert property (p_l3) else $error("pin3 high");
  property p_h4; w4 && pwdata_i[3:0] == 1 |-> ##2 aux_output_four_o; endproperty
  a_h4: assert property (p_h4) else $error("pin4 low");
  property p_l4; w4 && pwdata_i[3:0] == 0 |-> ##2 !aux_output_four_o; endproperty
  a_l4: assert property (p_l4) else $error("pin4 high");
  property p_rd; rd |-> prdata_o[31:4] == 0; endproperty
  a_rd: assert property (p_rd) else $error("upper bits");
  property p_er; acc |-> pslverr_o == !hit; endproperty
  a_er: assert property (p_er) else $error("error flag");
  property p_zr; rd && !hit |-> prdata_o == 0; endproperty
  a_zr: assert property (p_zr) else $error("miss data");
  property p_rs; $rose(rstn_i) |-> !aux_output_three_o && !aux_output_four_o; endproperty
  a_rs: assert property (p_rs) else $error("pins set");
endmodule // aosm_props
bind aosm_aux_output_source_mux aosm_props i_props (.*);

//--- verif/tb_aux_output_source_mux.sv
// Self-checking bench for the aux output selector
`timescale 1ns/1ps
module tb_aux_output_source_mux;
  logic mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic [3:0] pstrb_i = 0;
  logic [13:0] s = 0, pat [2] = '{14'h2a5b, 14'h15a4};
  logic pready_o, pslverr_o, aux_output_three_o, aux_output_four_o;
  int miscompares = 0, checked = 0, rises, r0;
  always #25 mclk_i = ~mclk_i;
  aosm_aux_output_source_mux i_dut (.*, .rate_converter_irq_n_i(s[0]), .tx_irq_n_i(s[1]), .rx_irq_n_i(s[2]),
    .rx_preemph_n_i(s[3]), .rx_nonaudio_i(s[4]), .rx_nonvalid_i(s[5]), .rx_cs_bit_i(s[6]), .rx_user_bit_i(s[7]),
    .rx_block_clk_i(s[8]), .rx_copy_i(s[9]), .rx_generation_i(s[10]), .rx_parity_err_i(s[11]),
    .rx_sync_clk_i(s[12]), .tx_sync_clk_i(s[13]));
  aosm_pin_watch i_pw (.rstn_i(rstn_i), .pin_i(aux_output_three_o), .rises_o(rises));
  task automatic chk(input string n, input logic [31:0] e, v);
    checked++;
    if (v !== e) miscompares++;
    if (v !== e) $display("[FAIL] %s exp %h got %h", n, e, v);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge mclk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} <= {1'b1, w, a, d, 4'hf};
    @(posedge mclk_i);
    penable_i <= 1;
    do @(posedge mclk_i); while (pready_o !== 1'b1 && ++n < 20);
    chk("pready", 1, pready_o);
    if (n == 20) finish_test();
    {rd, err} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b0;
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1;
    repeat (2) @(posedge mclk_i);
    foreach (pat[p]) begin
      for (int c = 0; c < 16; c++) begin
        s <= pat[p];
        // Upper write bits set on purpose, they must read back as zero
        apb(1, 12'h074, {28'hfffffff, c[3:0]});
        apb(1, 12'h078, 15 - c);
        apb(0, 12'h074, 0);
        chk("reg3", c, rd);
        apb(0, 12'h078, 0);
        chk("reg4", 15 - c, rd);
        repeat (3) @(posedge mclk_i);
        chk("pin3", {pat[p], 2'b10} >> c & 1, aux_output_three_o);
        chk("pin4", {pat[p], 2'b10} >> 15 - c & 1, aux_output_four_o);
      end
    end
    apb(0, 12'h07c, 0);
    chk("miss", 1, err);
    apb(1, 12'h074, 2);
    r0 = rises;
    repeat (6) begin
      s[0] <= ~s[0];
      repeat (4) @(posedge mclk_i);
    end
    chk("edges", 3, rises - r0);
    // Reset in mid-run must bring both pins and out_four_source_select back to their defaults
    apb(1, 12'h078, 1);
    repeat (2) @(posedge mclk_i);
    chk("pin4 set", 1, aux_output_four_o);
    rstn_i <= 0;
    repeat (2) @(posedge mclk_i);
    chk("pin3 rst", 0, aux_output_three_o);
    chk("pin4 rst", 0, aux_output_four_o);
    rstn_i <= 1;
    repeat (3) @(posedge mclk_i);
    apb(0, 12'h078, 0);
    chk("reg4 rst", 0, rd);
    finish_test();
  end
endmodule // tb_aux_output_source_mux
